// File: pkg/pcr_pkg.sv
// constants for the port configuration, reset and power-down block
package pcr_pkg;
  // ***************************************************************
  // register bus
  // ***************************************************************
  localparam int         ADDR_W      = 4;
  localparam int         DATA_W      = 32;
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_ADV     = 4'h4;
  localparam logic [3:0] OFS_STAT    = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CB_SWRST  = 15;
  localparam int CB_LOOP   = 14;
  localparam int CB_SPEED  = 13;
  localparam int CB_ANEN   = 12;
  localparam int CB_PWRDN  = 11;
  localparam int CB_ANRST  = 9;
  localparam int CB_DUPLEX = 8;
  localparam int AB_LO     = 5;
  localparam int AB_HI     = 8;
  localparam int SB_BUSY   = 0;
  localparam int SB_HWMODE = 1;
  localparam int SB_FIBER  = 2;
  localparam int SB_ACTIVE = 3;
  localparam int SB_SWRST  = 4;
  localparam int SB_PPD    = 5;
  // ***************************************************************
  // values after reset and advertisement patterns
  // ***************************************************************
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ADV_RST  = 16'h0001;
  localparam logic [3:0]  ADV_ALL  = 4'hF;
  localparam logic [3:0]  ADV_100  = 4'hC;
  localparam logic [3:0]  ADV_10   = 4'h3;
  localparam logic [3:0]  ADV_HALF = 4'h5;
  // ***************************************************************
  // synchroniser lanes
  // ***************************************************************
  localparam int SYNC_N  = 8;
  localparam int I_MEDIA = 0;
  localparam int I_AN    = 1;
  localparam int I_SPEED = 2;
  localparam int I_DUP   = 3;
  localparam int I_HWM   = 4;
  localparam int I_GPD   = 5;
  localparam int I_PPD   = 6;
  localparam int I_LFAIL = 7;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_KHZ      = 40000;
  localparam int INIT_WAIT_US = 1000;
  localparam int INIT_CYCLES  = (INIT_WAIT_US * CLK_KHZ) / 1000;
  localparam int SWRST_CYCLES = 16;
endpackage

// File: core/pcr_port_cfg.sv
// per-port strap loader, reset and power-down control with AXI4-Lite regs
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - apply configuration after reset or link failure
// - management mode: straps only give defaults
// - pin mode: management writes ignored, straps load
// - forced mode starts at once, else autonegotiation
// - global power-down freezes everything, registers kept
// - power-down release reloads last hardware-reset values
// - no traffic during any power-down
// - software power-down bit stops port, registers live
// - port power-down pin: stop, tristate, refuse access
// - port pin release reloads, no strap resample
// - hardware reset loads speed, autoneg, duplex bits
// - software reset restores snapshot, no resample
// - reset bit readable, reads zero when done
// - registers unavailable 1 ms after reset
// - MII pins disabled during hardware reset
// - fiber strap low: 100 FX, autoneg off
// - all straps high: advertise everything
// - duplex strap low: advertise 100 only
// - speed strap low: advertise 10 only
// - speed and duplex low: advertise half only
// - autoneg strap low: force speed and duplex
// - media strap sampled only at reset end
// - writing autoneg enable one starts autonegotiation
module pcr_port_cfg #(
  parameter int INIT_CYCLES = pcr_pkg::INIT_CYCLES
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  // straps and power pins
  input  wire logic                        MEDIA_SELECT_STRAP,
  input  wire logic                        AUTONEG_STRAP,
  input  wire logic                        SPEED_STRAP,
  input  wire logic                        DUPLEX_STRAP,
  input  wire logic                        HW_CTRL_MODE,
  input  wire logic                        GLOBAL_POWERDOWN,
  input  wire logic                        PORT_POWERDOWN_PIN,
  input  wire logic                        LINK_FAIL,
  // AXI4-Lite write
  input  wire logic [pcr_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output var  logic                        S_AXI_AWREADY,
  input  wire logic [pcr_pkg::DATA_W-1:0]  S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output var  logic                        S_AXI_WREADY,
  output var  logic [1:0]                  S_AXI_BRESP,
  output var  logic                        S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [pcr_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output var  logic                        S_AXI_ARREADY,
  output var  logic [pcr_pkg::DATA_W-1:0]  S_AXI_RDATA,
  output var  logic [1:0]                  S_AXI_RRESP,
  output var  logic                        S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  // port control
  output var  logic                        CFG_AN_EN,
  output var  logic                        CFG_SPEED_100,
  output var  logic                        CFG_FULL_DUPLEX,
  output var  logic                        CFG_FIBER,
  output var  logic                        CFG_LOOPBACK,
  output var  logic [3:0]                  CFG_ADV,
  output var  logic                        AN_START,
  output var  logic                        FORCED_START,
  output var  logic                        PORT_ACTIVE,
  output var  logic                        PORT_CLK_EN,
  output var  logic                        MII_OE_N
);
  import pcr_pkg::*;

  localparam int CW = $clog2(INIT_CYCLES + 1);

  if (INIT_CYCLES < 1) begin : g_chk
    $error("INIT_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    ST_LOAD, ST_HOLD, ST_RUN, ST_GPD, ST_PPD
  } pcr_state_t;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // {an_en, speed_100, full_duplex, adv[3:0]} from the straps
  function automatic logic [6:0] strap_cfg(input logic [3:0] s);
    logic [3:0] adv;
    adv = ADV_ALL;
    if (!s[I_MEDIA])
      return {1'b0, 1'b1, s[I_DUP], ADV_ALL};
    if (s[I_AN]) begin
      unique case ({s[I_SPEED], s[I_DUP]})
        2'b11: adv = ADV_ALL;
        2'b10: adv = ADV_100;
        2'b01: adv = ADV_10;
        2'b00: adv = ADV_HALF;
      endcase
    end
    return {s[I_AN], s[I_SPEED], s[I_DUP], adv};
  endfunction

  function automatic logic [15:0] cfg_ctrl(input logic [6:0] c);
    logic [15:0] r;
    r = CTRL_RST;
    r[CB_ANEN]   = c[6];
    r[CB_SPEED]  = c[5];
    r[CB_DUPLEX] = c[4];
    return r;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [SYNC_N-1:0] sync1;
  logic [SYNC_N-1:0] sync2;
  logic              lfail_q;

  always_ff @(posedge CLK) begin
    sync1 <= {LINK_FAIL, PORT_POWERDOWN_PIN, GLOBAL_POWERDOWN,
              HW_CTRL_MODE, DUPLEX_STRAP, SPEED_STRAP, AUTONEG_STRAP,
              MEDIA_SELECT_STRAP};
    sync2   <= sync1;
    lfail_q <= sync2[I_LFAIL];
  end

  wire logic gpd     = sync2[I_GPD];
  wire logic ppd     = sync2[I_PPD];
  wire logic hw_mode = sync2[I_HWM];
  wire logic lf_rise = sync2[I_LFAIL] && !lfail_q;

  // ***************************************************************
  // state machine
  // ***************************************************************
  pcr_state_t      state;
  pcr_state_t      next_state;
  logic [CW-1:0]   wait_cnt;
  logic [4:0]      swrst_cnt;
  logic            apply_q;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOAD: next_state = ST_HOLD;
      ST_HOLD: begin
        if (gpd)
          next_state = ST_GPD;
        else if (ppd)
          next_state = ST_PPD;
        else if (wait_cnt == '0)
          next_state = ST_RUN;
      end
      ST_RUN, ST_PPD: begin
        if (gpd)
          next_state = ST_GPD;
        else if (ppd)
          next_state = ST_PPD;
        else
          next_state = ST_RUN;
      end
      ST_GPD: begin
        if (!gpd)
          next_state = ppd ? ST_PPD : ST_RUN;
      end
    endcase
  end

  wire logic in_pd    = (state == ST_GPD) || (state == ST_PPD);
  wire logic reload   = in_pd && (next_state == ST_RUN);
  wire logic swrst_on = (swrst_cnt != '0);
  wire logic swrst_dn = (swrst_cnt == 5'h01);
  wire logic apply    = (state == ST_HOLD && next_state == ST_RUN)
                     || reload || swrst_dn
                     || (state == ST_RUN && lf_rise);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state    <= ST_LOAD;
      wait_cnt <= '0;
      apply_q  <= 1'b0;
    end else begin
      state   <= next_state;
      apply_q <= apply;
      if (state == ST_LOAD)
        wait_cnt <= CW'(INIT_CYCLES - 1);
      else if (wait_cnt != '0)
        wait_cnt <= wait_cnt - 1'b1;
    end
  end

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              aw_got;
  logic              w_got;

  wire logic reg_open = (state == ST_RUN);
  wire logic wr_do    = aw_got && w_got && !S_AXI_BVALID;
  wire logic wr_map   = (aw_addr == OFS_CTRL) || (aw_addr == OFS_ADV)
                     || (aw_addr == OFS_STAT);
  wire logic wr_ok    = wr_do && reg_open && wr_map && !hw_mode;
  wire logic wr_ctrl  = wr_ok && (aw_addr == OFS_CTRL);
  wire logic wr_adv   = wr_ok && (aw_addr == OFS_ADV);
  wire logic swrst_go = wr_ctrl && w_strb[1] && w_data[CB_SWRST];
  wire logic an_kick  = wr_ctrl && w_strb[1] && !w_data[CB_SWRST]
                     && (w_data[CB_ANEN] || w_data[CB_ANRST]);
  wire logic rd_do    = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic rd_map   = (S_AXI_ARADDR == OFS_CTRL)
                     || (S_AXI_ARADDR == OFS_ADV)
                     || (S_AXI_ARADDR == OFS_STAT);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr       <= S_AXI_AWADDR;
        aw_got        <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
        w_got        <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_do) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (reg_open && wr_map) ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        aw_got        <= 1'b0;
        w_got         <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // register file
  // ***************************************************************
  logic [15:0] ctrl;
  logic [15:0] adv;
  logic [6:0]  snap;
  logic        fiber;

  wire logic [6:0] strap_now = strap_cfg(sync2[3:0]);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl      <= CTRL_RST;
      adv       <= ADV_RST;
      snap      <= '0;
      fiber     <= 1'b0;
      swrst_cnt <= '0;
    end else begin
      if (swrst_go)
        swrst_cnt <= 5'(SWRST_CYCLES);
      else if (swrst_on)
        swrst_cnt <= swrst_cnt - 1'b1;
      if (state == ST_LOAD) begin
        snap  <= strap_now;
        fiber <= !sync2[I_MEDIA];
        ctrl  <= cfg_ctrl(strap_now);
        adv   <= {ADV_RST[15:AB_HI+1], strap_now[3:0], ADV_RST[AB_LO-1:0]};
      end else if (reload || swrst_go) begin
        ctrl <= cfg_ctrl(snap);
        adv  <= {ADV_RST[15:AB_HI+1], snap[3:0], ADV_RST[AB_LO-1:0]};
      end else if (wr_ctrl) begin
        ctrl <= merge(ctrl, w_data, w_strb) & ~16'h8200;
      end else if (wr_adv) begin
        adv <= merge(adv, w_data, w_strb);
      end
    end
  end

  wire logic [15:0] ctrl_rd = {swrst_on, ctrl[14:0]};
  wire logic [15:0] stat_rd = {10'h000, ppd, swrst_on, PORT_ACTIVE,
                               fiber, hw_mode, state == ST_HOLD};
  wire logic [15:0] rd_word = (S_AXI_ARADDR == OFS_CTRL) ? ctrl_rd
                            : (S_AXI_ARADDR == OFS_ADV)  ? adv
                            : (S_AXI_ARADDR == OFS_STAT) ? stat_rd
                            : 16'h0000;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (rd_do) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= (reg_open && rd_map) ? {16'h0000, rd_word} : '0;
      S_AXI_RRESP   <= (reg_open && rd_map) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ***************************************************************
  // port control outputs
  // ***************************************************************
  wire logic an_eff = ctrl[CB_ANEN] && !fiber;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CFG_AN_EN       <= 1'b0;
      CFG_SPEED_100   <= 1'b0;
      CFG_FULL_DUPLEX <= 1'b0;
      CFG_FIBER       <= 1'b0;
      CFG_LOOPBACK    <= 1'b0;
      CFG_ADV         <= '0;
      AN_START        <= 1'b0;
      FORCED_START    <= 1'b0;
      PORT_ACTIVE     <= 1'b0;
      PORT_CLK_EN     <= 1'b0;
      MII_OE_N        <= 1'b1;
    end else begin
      CFG_AN_EN       <= an_eff;
      CFG_SPEED_100   <= ctrl[CB_SPEED] || fiber;
      CFG_FULL_DUPLEX <= ctrl[CB_DUPLEX];
      CFG_FIBER       <= fiber;
      CFG_LOOPBACK    <= ctrl[CB_LOOP];
      CFG_ADV         <= adv[AB_HI:AB_LO];
      AN_START        <= (apply_q && an_eff)
                      || (an_kick && !fiber && reg_open);
      FORCED_START    <= apply_q && !an_eff;
      PORT_ACTIVE     <= (state == ST_RUN) && !swrst_on
                      && !ctrl[CB_PWRDN];
      PORT_CLK_EN     <= !in_pd && !gpd && !ppd;
      MII_OE_N        <= in_pd || gpd || ppd;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_swrst_busy;
    ctrl_rd[CB_SWRST] [*8];
  endsequence
  sequence s_swrst_done;
    ##[1:12] !ctrl_rd[CB_SWRST];
  endsequence
  sequence s_pd_exit;
    in_pd ##1 (state == ST_RUN);
  endsequence

  property p_hw_nowrite;
    (wr_do && hw_mode && !reload) |=> $stable(adv) && $stable(ctrl);
  endproperty
  a_hw_nowrite: assert property (p_hw_nowrite)
    else $error("write changed a register in pin mode");

  property p_apply_start;
    apply |=> ##1 (AN_START || FORCED_START);
  endproperty
  a_apply_start: assert property (p_apply_start)
    else $error("no start pulse after configuration");

  property p_gpd_hold;
    (state == ST_GPD && $past(state) == ST_GPD) |-> $stable(ctrl)
      && $stable(adv);
  endproperty
  a_gpd_hold: assert property (p_gpd_hold)
    else $error("registers changed in global power-down");

  property p_pd_reload;
    s_pd_exit |-> (ctrl[CB_ANEN] == snap[6])
      && (adv[AB_HI:AB_LO] == snap[3:0]);
  endproperty
  a_pd_reload: assert property (p_pd_reload)
    else $error("registers not reloaded after power-down");

  property p_pd_quiet;
    in_pd |=> !PORT_ACTIVE && MII_OE_N && !PORT_CLK_EN;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("port active during power-down");

  property p_swpd;
    (ctrl[CB_PWRDN] && state == ST_RUN && !gpd && !ppd)
      |=> !PORT_ACTIVE && PORT_CLK_EN;
  endproperty
  a_swpd: assert property (p_swpd)
    else $error("software power-down misbehaves");

  property p_refuse;
    (rd_do && state != ST_RUN) |=> S_AXI_RRESP == RESP_SLVERR;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("register read accepted while closed");

  property p_swrst;
    swrst_go |=> s_swrst_busy ##0 s_swrst_done;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("software reset bit timing wrong");

  property p_mii_reset;
    $rose(RESET_N) |-> MII_OE_N;
  endproperty
  a_mii_reset: assert property (p_mii_reset)
    else $error("MII pins driven during reset");

  property p_strap_load;
    (state == ST_LOAD) |=> (snap == $past(strap_now))
      && (adv[AB_HI:AB_LO] == $past(strap_now[3:0]));
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap decode not loaded");

endmodule // pcr_port_cfg
`default_nettype wire

// File: test/pcr_mgmt_model.sv
// management controller model: AXI4-Lite master with bus tasks
`timescale 1ns/100ps
`default_nettype none
module pcr_mgmt_model (
  // clock
  input  wire logic                       clk,
  // write channels
  output var  logic [pcr_pkg::ADDR_W-1:0] awaddr,
  output var  logic                       awvalid,
  input  wire logic                       awready,
  output var  logic [31:0]                wdata,
  output var  logic [3:0]                 wstrb,
  output var  logic                       wvalid,
  input  wire logic                       wready,
  input  wire logic [1:0]                 bresp,
  input  wire logic                       bvalid,
  output var  logic                       bready,
  // read channels
  output var  logic [pcr_pkg::ADDR_W-1:0] araddr,
  output var  logic                       arvalid,
  input  wire logic                       arready,
  input  wire logic [31:0]                rdata,
  input  wire logic [1:0]                 rresp,
  input  wire logic                       rvalid,
  output var  logic                       rready
);
  import pcr_pkg::*;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
  end
  // ***********************************************************
  // bus cycles; any answer accepted, caller judges it
  // ***********************************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end while (!(ta && tw));
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // pcr_mgmt_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the port configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pcr_pkg::*;
  localparam int INIT_N = 20;
  logic CLK, RESET_N, hwm, gpd, ppd, lfail;
  logic [3:0] strap, k, adv, aw, ar, ws;
  logic [31:0] wd, rdt, d, v;
  logic [1:0] br, rr, r;
  logic awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry;
  logic an_en, spd, dup, fib, ast, fst, act, cke, oe_n, lb;
  int failures = 0, checked = 0, seed = 27450, n_an = 0, n_fs = 0, a0;
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (ast) n_an <= n_an + 1;
    if (fst) n_fs <= n_fs + 1;
  end
  pcr_port_cfg #(.INIT_CYCLES(INIT_N)) dut (.CLK(CLK), .RESET_N(RESET_N),
    .MEDIA_SELECT_STRAP(strap[3]), .AUTONEG_STRAP(strap[2]),
    .SPEED_STRAP(strap[1]), .DUPLEX_STRAP(strap[0]), .HW_CTRL_MODE(hwm),
    .GLOBAL_POWERDOWN(gpd), .PORT_POWERDOWN_PIN(ppd), .LINK_FAIL(lfail),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .CFG_AN_EN(an_en),
    .CFG_SPEED_100(spd), .CFG_FULL_DUPLEX(dup), .CFG_FIBER(fib),
    .CFG_LOOPBACK(lb), .CFG_ADV(adv), .AN_START(ast), .FORCED_START(fst),
    .PORT_ACTIVE(act), .PORT_CLK_EN(cke), .MII_OE_N(oe_n));
  pcr_mgmt_model mgr (.clk(CLK), .awaddr(aw), .awvalid(awv), .awready(awr),
    .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr_), .bresp(br),
    .bvalid(bv), .bready(bry), .araddr(ar), .arvalid(arv), .arready(arr),
    .rdata(rdt), .rresp(rr), .rvalid(rv), .rready(rry));
  // ***********************************************************
  // expectations and checks
  // ***********************************************************
  function automatic logic [3:0] e_cfg(input logic [3:0] t);
    return {t[3] & t[2], t[1] | ~t[3], t[0], ~t[3]};
  endfunction
  function automatic logic [3:0] e_adv(input logic [3:0] t);
    if (!t[3] || !t[2]) return 4'hF;
    case (t[1:0])
      2'b11: return 4'hF;
      2'b10: return 4'hC;
      2'b01: return 4'h3;
      default: return 4'h5;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e, g);
    chk(n, {14'h0, e}, {14'h0, g});
  endtask
  task automatic chk_cfg(input logic [3:0] t);
    @(negedge CLK);
    chk("cfg", {12'h0, e_cfg(t)}, {12'h0, an_en, spd, dup, fib});
    chk("adv", {12'h0, e_adv(t)}, {12'h0, adv});
  endtask
  task automatic hw_reset(input logic [3:0] t);
    int f0;
    @(posedge CLK);
    strap <= t;
    RESET_N <= 1'b0;
    repeat (16) @(posedge CLK);
    a0 = n_an;
    f0 = n_fs;
    chk("mii_oe_n", 16'h1, {15'h0, oe_n});
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk_cfg(t);
    chk("mii_oe_n", 16'h0, {15'h0, oe_n});
    mgr.rd(OFS_STAT, d, r);
    chk_resp("init_resp", RESP_SLVERR, r);
    repeat (INIT_N + 8) @(posedge CLK);
    k = e_cfg(t);
    chk("starts", {7'h0, k[3], 7'h0, ~k[3]},
        {8'(n_an - a0), 8'(n_fs - f0)});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    finish_test();
  end
  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    {RESET_N, hwm, gpd, ppd, lfail} = '0;
    strap = 4'hF;
    for (int i = 0; i < 16; i++) hw_reset(i[3:0]);
    $display("strap table done");
    mgr.wr(OFS_CTRL, 32'h0000_6100, r);
    mgr.rd(OFS_CTRL, d, r);
    chk("ctrl", 16'h6100, d[15:0]);
    chk_cfg(4'hB);
    chk("loop", 16'h1, {15'h0, lb});
    a0 = n_an;
    mgr.wr(OFS_CTRL, 32'h0000_3100, r);
    repeat (4) @(posedge CLK);
    chk("an_start", 16'h1, 16'(n_an - a0));
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      mgr.wr(OFS_ADV, v, r);
      mgr.rd(OFS_ADV, d, r);
      chk("adv_reg", {12'h0, v[8:5]}, {12'h0, d[8:5]});
    end
    mgr.rd(4'hC, d, r);
    chk_resp("unmapped", RESP_SLVERR, r);
    @(posedge CLK);
    strap <= 4'h0;
    mgr.wr(OFS_CTRL, 32'h0000_8000, r);
    mgr.rd(OFS_CTRL, d, r);
    chk("swrst_busy", 16'h1, {15'h0, d[15]});
    for (int n = 0; n < 30 && d[15] !== 1'b0; n++) mgr.rd(OFS_CTRL, d, r);
    chk("swrst_done", 16'h0, {15'h0, d[15]});
    chk_cfg(4'hF);
    chk("loop_rst", 16'h0, {15'h0, lb});
    mgr.wr(OFS_CTRL, 32'h0000_0800, r);
    mgr.rd(OFS_CTRL, d, r);
    chk_resp("swpd_resp", RESP_OKAY, r);
    chk("swpd", 16'h1, {15'h0, d[11]});
    chk("swpd_act", 16'h0, {15'h0, act});
    $display("management access done");
    for (int p = 0; p < 2; p++) begin
      mgr.wr(OFS_CTRL, 32'h0000_0100, r);
      gpd <= (p == 0);
      ppd <= (p == 1);
      repeat (6) @(posedge CLK);
      chk("pd_port", 16'h1, {13'h0, act, cke, oe_n});
      mgr.rd(OFS_CTRL, d, r);
      chk_resp("pd_resp", RESP_SLVERR, r);
      gpd <= 1'b0;
      ppd <= 1'b0;
      repeat (8) @(posedge CLK);
      chk_cfg(4'hF);
    end
    $display("power-down done");
    a0 = n_an;
    lfail <= 1'b1;
    repeat (8) @(posedge CLK);
    lfail <= 1'b0;
    chk("lfail_start", 16'h1, 16'(n_an - a0));
    $display("link failure done");
    hwm <= 1'b1;
    repeat (4) @(posedge CLK);
    mgr.wr(OFS_ADV, $random(seed) & 32'h0000_0000, r);
    chk_resp("pin_resp", RESP_OKAY, r);
    chk_cfg(4'hF);
    hwm <= 1'b0;
    $display("pin mode done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
